// ===== verilog/fiu_flags_ip.v
// Purpose: Status/control flag register and next-instruction offset pointer
// Assumes: Execution logic gives one-cycle event pulses on clk
// Notes:   APB slave, zero wait states; all outputs registered
//
// Local design decisions: the register addresses and the APB register port.
`include "fiu_consts.vh"

module fiu_flags_ip (
  input  wire        clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Arithmetic result update
  input  wire        aluValid,
  input  wire [1:0]  aluOp,
  input  wire [31:0] aluA,
  input  wire [31:0] aluB,
  output reg  [31:0] aluResult,
  // Instruction flow
  input  wire        retireValid,
  input  wire [3:0]  retireLen,
  input  wire        redirectValid,
  input  wire [31:0] redirectTarget,
  output reg  [31:0] nextInstrOffset,
  output reg         singleStepReq,
  // Maskable interrupt pin
  input  wire        maskableIrqInput,
  output reg         irqTake,
  // String step
  input  wire        strStep,
  input  wire [2:0]  strSize,
  output reg  [31:0] strDelta,
  // Flag word loads
  input  wire        popValid,
  input  wire        popWide,
  input  wire        iretValid,
  input  wire        taskSwitchValid,
  input  wire [31:0] loadData,
  // Protection checks
  input  wire        ioCheck,
  output reg         ioPermitted,
  output reg         ioNeedBitmap,
  input  wire        dbgBreakHit,
  output reg         dbgFault,
  input  wire        privilegedOp,
  output reg         legacyFault,
  output reg         legacySegLoads,
  input  wire        memAccess,
  input  wire        memMisaligned,
  output reg         alignFault,
  output reg         nestedTask,
  output reg  [31:0] statusControlFlags
);

  // ==========================================================
  // Functions
  function evenParity8;
    input [7:0] v;
    begin
      evenParity8 = ~(^v);
    end
  endfunction

  function [31:0] flagImage;
    input [31:0] v;
    begin
      flagImage = (v & `FIU_FLAGS_WMASK) | `FIU_FLAGS_FIXED;
    end
  endfunction

  // ==========================================================
  // State
  reg  [31:0] flags;
  reg  [31:0] nextIp;
  reg  [31:0] controlReg;
  reg         irqS1;
  reg         irqS2;
  reg         irqS3;
  reg         irqLevel;

  // Write mask as a parameter so the pop paths can take its halves
  localparam [31:0] FLAGS_WMASK = `FIU_FLAGS_WMASK;

  wire        protMode   = controlReg[`FIU_CTL_PROT_BIT];
  wire [1:0]  current_priv_level        = controlReg[`FIU_CTL_CPL_HI:`FIU_CTL_CPL_LO];
  wire        alignMask  = controlReg[`FIU_CTL_AMASK_BIT];
  wire [1:0]  ioPriv     = flags[`FIU_IO_PRIV_LEVEL_HI:`FIU_IO_PRIV_LEVEL_LO];
  wire        privOk     = ~protMode | (current_priv_level <= ioPriv);
  wire        legacyOn   = protMode & flags[`FIU_LEGACY_BIT];

  // ==========================================================
  // APB decode
  wire        apbSetup   = psel & ~penable;
  wire        apbWrite   = psel & penable & pwrite;
  wire        wrFlags    = apbWrite & (paddr == `FIU_OFF_FLAGS);
  wire        wrIp       = apbWrite & (paddr == `FIU_OFF_NEXT_IP);
  wire        wrCtl      = apbWrite & (paddr == `FIU_OFF_CONTROL);
  reg  [31:0] readMux;
  reg         readErr;

  always @* begin
    readErr = 1'b0;
    if (paddr == `FIU_OFF_FLAGS) begin
      readMux = flagImage(flags);
    end else if (paddr == `FIU_OFF_NEXT_IP) begin
      readMux = nextIp;
    end else if (paddr == `FIU_OFF_CONTROL) begin
      readMux = controlReg & `FIU_CTL_WMASK;
    end else if (paddr == `FIU_OFF_STATUS) begin
      readMux = {30'h0000_0000, legacyOn, irqLevel};
    end else begin
      readMux = 32'h0000_0000;
      readErr = 1'b1;
    end
  end

  // ==========================================================
  // Arithmetic flags
  wire        isSub   = (aluOp == `FIU_OP_SUB) | (aluOp == `FIU_OP_SBB);
  wire        useCy   = (aluOp == `FIU_OP_ADC) | (aluOp == `FIU_OP_SBB);
  wire        cyIn    = flags[`FIU_CARRY_BIT] & useCy;
  wire [31:0] bOper   = isSub ? ~aluB : aluB;
  // Subtraction as a + ~b + 1, borrow-in folded into the +1
  wire        addIn   = isSub ? ~cyIn : cyIn;
  wire [32:0] sum     = {1'b0, aluA} + {1'b0, bOper} + {32'h0000_0000, addIn};
  wire [31:0] res     = sum[31:0];
  wire        cyOut   = sum[32];
  wire        cyInTop = aluA[31] ^ bOper[31] ^ res[31];
  wire        cyBit3  = aluA[4] ^ aluB[4] ^ res[4];

  // ==========================================================
  // Next flag value
  reg  [31:0] next_flags;
  reg         trapFire;

  always @* begin
    next_flags = flags;
    trapFire   = 1'b0;
    if (wrFlags) begin
      next_flags = pwdata & `FIU_FLAGS_WMASK;
    end
    if (popValid) begin
      if (popWide) begin
        next_flags[31:16] = loadData[31:16] & FLAGS_WMASK[31:16];
        // Popping flags never enters legacy mode
        next_flags[`FIU_LEGACY_BIT] = flags[`FIU_LEGACY_BIT];
      end
      // Narrow pop touches only the low word
      next_flags[15:0] = loadData[15:0] & FLAGS_WMASK[15:0];
      if (!privOk) begin
        next_flags[`FIU_IRQEN_BIT] = flags[`FIU_IRQEN_BIT];
      end
      if (protMode && (current_priv_level != 2'h0)) begin
        next_flags[`FIU_IO_PRIV_LEVEL_HI:`FIU_IO_PRIV_LEVEL_LO] = ioPriv;
      end
    end
    if (iretValid) begin
      next_flags = loadData & `FIU_FLAGS_WMASK;
      if (!privOk) begin
        next_flags[`FIU_IRQEN_BIT] = flags[`FIU_IRQEN_BIT];
      end
      if (protMode && (current_priv_level != 2'h0)) begin
        next_flags[`FIU_LEGACY_BIT] = flags[`FIU_LEGACY_BIT];
        next_flags[`FIU_IO_PRIV_LEVEL_HI:`FIU_IO_PRIV_LEVEL_LO] = ioPriv;
      end
    end
    if (taskSwitchValid) begin
      next_flags = loadData & `FIU_FLAGS_WMASK;
    end
    if (aluValid) begin
      next_flags[`FIU_CARRY_BIT]  = isSub ? ~cyOut : cyOut;
      next_flags[`FIU_PARITY_BIT] = evenParity8(res[7:0]);
      next_flags[`FIU_AUX_BIT]    = cyBit3;
      next_flags[`FIU_ZERO_BIT]   = (res == 32'h0000_0000);
      next_flags[`FIU_SIGN_BIT]   = res[31];
      next_flags[`FIU_OVF_BIT]    = cyInTop ^ cyOut;
    end
    // Trap armed before this instruction fires at its end
    if (retireValid && flags[`FIU_TRAP_BIT]) begin
      trapFire = 1'b1;
      next_flags[`FIU_TRAP_BIT] = 1'b0;
    end
    // Resume covers exactly one instruction
    if (retireValid && !(popValid || iretValid || taskSwitchValid)) begin
      next_flags[`FIU_RESUME_BIT] = 1'b0;
    end
  end

  // ==========================================================
  // Next offset
  reg  [31:0] next_ip;

  always @* begin
    next_ip = nextIp;
    if (wrIp) begin
      next_ip = pwdata;
    end
    if (redirectValid) begin
      next_ip = redirectTarget;
    end else if (retireValid) begin
      next_ip = nextIp + {28'h000_0000, retireLen};
    end
  end

  // ==========================================================
  // String step size
  wire [31:0] stepSize = {29'h0000_0000, strSize};
  wire [31:0] next_strDelta = flags[`FIU_DIR_BIT] ? (32'h0000_0000 - stepSize) : stepSize;

  // ==========================================================
  // Core state
  // All updates funnel through the next_ values above
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags  <= `FIU_FLAGS_RESET;
      nextIp <= `FIU_NEXT_IP_RESET;
    end else begin
      flags  <= next_flags;
      nextIp <= next_ip;
    end
  end

  // ==========================================================
  // Control register
  // No privilege check on the bus side; only trusted code reaches it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      controlReg <= `FIU_CTL_RESET;
    end else if (wrCtl) begin
      controlReg <= pwdata & `FIU_CTL_WMASK;
    end
  end

  // ==========================================================
  // Interrupt pin synchroniser
  // Three stages; level moves only when the last two agree, so a
  // one-cycle glitch on the pin never reaches the accept logic
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqS1    <= 1'b0;
      irqS2    <= 1'b0;
      irqS3    <= 1'b0;
      irqLevel <= 1'b0;
    end else begin
      irqS1 <= maskableIrqInput;
      irqS2 <= irqS1;
      irqS3 <= irqS2;
      if (irqS2 == irqS3) begin
        irqLevel <= irqS3;
      end
    end
  end

  // ==========================================================
  // APB response
  // Zero wait states; read data is loaded at setup and stands
  // through the access phase, so a slow master still sees it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apbSetup) begin
        prdata  <= readMux;
        pslverr <= readErr;
      end
    end
  end

  // ==========================================================
  // Arithmetic result, held until the next operation
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aluResult <= 32'h0000_0000;
    end else if (aluValid) begin
      aluResult <= res;
    end
  end

  // ==========================================================
  // Offset and flag image copies
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nextInstrOffset    <= `FIU_NEXT_IP_RESET;
      statusControlFlags <= `FIU_FLAGS_RESET;
    end else begin
      nextInstrOffset    <= next_ip;
      statusControlFlags <= flagImage(next_flags);
    end
  end

  // ==========================================================
  // Single step and interrupt accept
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      singleStepReq <= 1'b0;
      irqTake       <= 1'b0;
    end else begin
      singleStepReq <= trapFire;
      // Accept only at a boundary with no trap pending
      irqTake <= retireValid & irqLevel & flags[`FIU_IRQEN_BIT] & ~trapFire;
    end
  end

  // ==========================================================
  // String step
  // Direction is read as stored; a same-cycle flag load applies next step
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strDelta <= 32'h0000_0000;
    end else if (strStep) begin
      strDelta <= next_strDelta;
    end
  end

  // ==========================================================
  // I/O permission and debug fault
  // Real mode always permits I/O
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ioPermitted  <= 1'b0;
      ioNeedBitmap <= 1'b0;
      dbgFault     <= 1'b0;
    end else begin
      ioPermitted  <= ioCheck & privOk;
      ioNeedBitmap <= ioCheck & protMode & ~privOk;
      dbgFault     <= dbgBreakHit & ~flags[`FIU_RESUME_BIT];
    end
  end

  // ==========================================================
  // Legacy mode, alignment and nesting
  // Mode levels follow next_flags so they line up with the image
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      legacyFault    <= 1'b0;
      legacySegLoads <= 1'b0;
      alignFault     <= 1'b0;
      nestedTask     <= 1'b0;
    end else begin
      legacyFault    <= privilegedOp & legacyOn;
      legacySegLoads <= protMode & next_flags[`FIU_LEGACY_BIT];
      // Mask bit gates the enable bit
      alignFault <= memAccess & memMisaligned & alignMask & flags[`FIU_ALIGN_BIT];
      nestedTask <= protMode & next_flags[`FIU_NEST_BIT];
    end
  end

endmodule // fiu_flags_ip

// ===== verilog/fiu_consts.vh
// Purpose: Constants for the flags and next-instruction offset unit
// Assumes: Included by fiu_flags_ip.v, the checker and the bench
// Notes:   Offsets are APB byte addresses
//
// Notes on behaviour
// - Offset register holds next instruction offset, advances unless redirected.
// - Low sixteen flag bits work alone as the old flag word.
// - Carry flag bit 0 marks carry or borrow out of the top bit.
// - Parity flag bit 2 set when low byte has even ones.
// - Aux carry bit 4 marks carry or borrow at bit three.
// - Zero flag bit 6 set only for a zero result.
// - Sign flag bit 7 copies the result top bit.
// - Trap bit 8 raises single-step after next instruction, which clears it.
// - Maskable interrupts taken only while interrupt enable bit 9 set.
// - String indexes step up when direction clear, down when set.
// - Overflow bit 11 set when exactly one of carry-in, carry-out at top.
// - Protected mode: I/O allowed without fault when privilege within field bits 12-13.
// - Popped flags change interrupt enable only if privilege within I/O field.
// - Nested task bit 14 shows task nested in protected mode.
// - Resume bit 16 suppresses debug faults on the next instruction.
// - Legacy mode bit 17: real-style segment loads, privileged opcodes fault 13.
// - Legacy mode set only by interrupt return at level 0 or task switch; an APB flags write also sets it.
// - Alignment bit 18 with mask bit decides misaligned access faults.
// - Alignment mask bit 18 zero blocks alignment faults, one lets them through.
`ifndef FIU_CONSTS_VH
`define FIU_CONSTS_VH

// ==========================================================
// Register map
`define FIU_OFF_FLAGS      8'h00
`define FIU_OFF_NEXT_IP    8'h04
`define FIU_OFF_CONTROL    8'h08
`define FIU_OFF_STATUS     8'h0c

// ==========================================================
// Flag bit positions
`define FIU_CARRY_BIT      0
`define FIU_PARITY_BIT     2
`define FIU_AUX_BIT        4
`define FIU_ZERO_BIT       6
`define FIU_SIGN_BIT       7
`define FIU_TRAP_BIT       8
`define FIU_IRQEN_BIT      9
`define FIU_DIR_BIT        10
`define FIU_OVF_BIT        11
`define FIU_IO_PRIV_LEVEL_LO        12
`define FIU_IO_PRIV_LEVEL_HI        13
`define FIU_NEST_BIT       14
`define FIU_RESUME_BIT     16
`define FIU_LEGACY_BIT     17
`define FIU_ALIGN_BIT      18

// Defined flag bits, fixed ones, reset image
`define FIU_FLAGS_WMASK    32'h0007_7fd5
`define FIU_FLAGS_FIXED    32'h0000_0002
`define FIU_FLAGS_RESET    32'h0000_0002
`define FIU_NEXT_IP_RESET  32'h0000_0000

// ==========================================================
// Control register fields
`define FIU_CTL_PROT_BIT   0
`define FIU_CTL_CPL_LO     1
`define FIU_CTL_CPL_HI     2
`define FIU_CTL_AMASK_BIT  18
`define FIU_CTL_WMASK      32'h0004_0007
`define FIU_CTL_RESET      32'h0000_0000

// ==========================================================
// Arithmetic operation codes
`define FIU_OP_ADD         2'h0
`define FIU_OP_SUB         2'h1
`define FIU_OP_ADC         2'h2
`define FIU_OP_SBB         2'h3

`endif

// ===== bench/fiu_flags_ip_assertions.sv
// Purpose: Port checker for the flags and offset unit
// Assumes: One clock domain, async active-low reset
// Notes:   Bench never writes the offset register over APB
`include "fiu_consts.vh"
module fiu_flags_ip_checker (
  input wire        clk, rstn, aluValid, retireValid, redirectValid,
  input wire        singleStepReq, irqTake, dbgBreakHit, dbgFault,
  input wire        memMisaligned, alignFault,
  input wire [3:0]  retireLen,
  input wire [31:0] aluResult, redirectTarget, nextInstrOffset, statusControlFlags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ========================================
  // Properties
  property p_sstep;
    retireValid && statusControlFlags[8] |=> singleStepReq && !statusControlFlags[8];
  endproperty
  a_sstep: assert property (p_sstep) else $error("single step missed");
  property p_nostep;
    !retireValid |=> !singleStepReq;
  endproperty
  a_nostep: assert property (p_nostep) else $error("stray single step");
  property p_zero;
    aluValid |=> statusControlFlags[6] == (aluResult == 32'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sign;
    aluValid |=> statusControlFlags[7] == aluResult[31];
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_parity;
    aluValid |=> statusControlFlags[2] == ~^aluResult[7:0];
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  property p_irq;
    irqTake |-> $past(statusControlFlags[9]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq taken while masked");
  property p_dbg;
    dbgBreakHit |=> dbgFault == !$past(statusControlFlags[16]);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug fault wrong");
  property p_align;
    alignFault |-> $past(statusControlFlags[18]) && $past(memMisaligned);
  endproperty
  a_align: assert property (p_align) else $error("align fault unexpected");
  property p_fixed;
    (statusControlFlags & ~`FIU_FLAGS_WMASK) == `FIU_FLAGS_FIXED;
  endproperty
  a_fixed: assert property (p_fixed) else $error("undefined flag bits moved");
  property p_redir;
    redirectValid |=> nextInstrOffset == $past(redirectTarget);
  endproperty
  a_redir: assert property (p_redir) else $error("redirect lost");
  property p_adv;
    retireValid && !redirectValid |=>
      nextInstrOffset == $past(nextInstrOffset) + $past(retireLen);
  endproperty
  a_adv: assert property (p_adv) else $error("offset not advanced");
  c_step: cover property (singleStepReq);
  c_irq: cover property (irqTake);
  c_align: cover property (alignFault);
endmodule // fiu_flags_ip_checker
bind fiu_flags_ip fiu_flags_ip_checker i_chk (.*);

// ===== bench/fiu_tb.sv
// Purpose: Self-checking bench for the flags and offset unit
// Assumes: Zero-wait APB slave, one-cycle event latency
// Notes:   Arithmetic cases are table rows
`include "fiu_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, psel, penable, pwrite, aluValid, retireValid, redirectValid;
  logic maskableIrqInput, strStep, popValid, popWide, iretValid, taskSwitchValid;
  logic ioCheck, dbgBreakHit, privilegedOp, memAccess, memMisaligned, err;
  logic [1:0] aluOp;
  logic [2:0] strSize;
  logic [3:0] retireLen;
  logic [7:0] paddr;
  logic [31:0] pwdata, aluA, aluB, redirectTarget, loadData, rdat;
  wire [31:0] prdata, aluResult, nextInstrOffset, strDelta, statusControlFlags;
  wire pready, pslverr, singleStepReq, irqTake, ioPermitted, ioNeedBitmap;
  wire dbgFault, legacyFault, legacySegLoads, alignFault, nestedTask;
  int miscompares = 0, checked = 0, cyc = 0;
  // Op, a, b, result, arithmetic flags; carry chains row to row
  logic [129:0] rows [6] = '{
    {2'h0, 32'hffff_ffff, 32'h1, 32'h0, 32'h55},
    {2'h0, 32'h7fff_ffff, 32'h1, 32'h8000_0000, 32'h894},
    {2'h1, 32'h0, 32'h1, 32'hffff_ffff, 32'h95},
    {2'h3, 32'h5, 32'h3, 32'h1, 32'h0},
    {2'h2, 32'h8000_0000, 32'h8000_0000, 32'h0, 32'h845},
    {2'h1, 32'h8000_0000, 32'h1, 32'h7fff_ffff, 32'h814}};
  fiu_flags_ip i_dut (.*);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ========================================
  // Tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick;
    @(posedge clk);
    {aluValid, retireValid, redirectValid, strStep, popValid, iretValid} <= 0;
    {taskSwitchValid, ioCheck, dbgBreakHit, privilegedOp, memAccess, memMisaligned} <= 0;
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin miscompares++; wrap_up; end
  end
  // ========================================
  // Sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, aluValid, aluOp, aluA, aluB} = 0;
    {retireValid, retireLen, redirectValid, redirectTarget, maskableIrqInput} = 0;
    {strStep, strSize, popValid, popWide, iretValid, taskSwitchValid, loadData} = 0;
    {ioCheck, dbgBreakHit, privilegedOp, memAccess, memMisaligned, rstn} = 0;
    repeat (20) @(posedge clk);
    rstn <= 1;
    tick;
    chk("flags reset", `FIU_FLAGS_RESET, statusControlFlags);
    chk("offset reset", 0, nextInstrOffset);
    chk("ready after reset", 1, pready);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk); aluValid <= 1; {aluOp, aluA, aluB} <= rows[i][129:64]; tick;
      chk("alu result", rows[i][63:32], aluResult);
      chk("alu flags", rows[i][31:0], statusControlFlags & 32'h8d5);
    end
    $display("arithmetic test done");
    apb(1, `FIU_OFF_FLAGS, 32'hffff_ffff);
    apb(0, `FIU_OFF_FLAGS, 0);
    chk("flags image", 32'h7_7fd7, rdat);
    @(posedge clk); popValid <= 1; popWide <= 0; loadData <= 0; tick;
    chk("narrow pop", 32'h7_0002, statusControlFlags);
    apb(1, `FIU_OFF_FLAGS, 32'h102);
    @(posedge clk); retireValid <= 1; retireLen <= 4'h3; tick;
    chk("step req", 1, singleStepReq);
    chk("trap clear", 0, statusControlFlags[8]);
    chk("advance", 3, nextInstrOffset);
    @(posedge clk); retireValid <= 1; redirectValid <= 1; redirectTarget <= 32'h1000; tick;
    chk("redirect", 32'h1000, nextInstrOffset);
    $display("flow test done");
    @(posedge clk); maskableIrqInput <= 1;
    for (int f = 1; f >= 0; f--) begin
      apb(1, `FIU_OFF_FLAGS, {22'h0, f[0], 9'h2});
      repeat (8) @(posedge clk);
      retireValid <= 1; tick;
      chk("irq take", f, irqTake);
    end
    apb(0, `FIU_OFF_STATUS, 0);
    chk("irq level", 1, rdat);
    for (int d = 0; d < 2; d++) begin
      apb(1, `FIU_OFF_FLAGS, {21'h0, d[0], 10'h2});
      @(posedge clk); strStep <= 1; strSize <= 3'h4; tick;
      chk("string delta", d ? 32'hffff_fffc : 32'h4, strDelta);
    end
    $display("irq and string test done");
    apb(1, `FIU_OFF_CONTROL, 32'h7);
    apb(1, `FIU_OFF_FLAGS, 32'h202);
    @(posedge clk); popValid <= 1; popWide <= 1; loadData <= 32'h2; tick;
    chk("pop keeps enable", 32'h202, statusControlFlags);
    @(posedge clk); iretValid <= 1; loadData <= 32'h2_0002; tick;
    chk("iret legacy", 0, statusControlFlags[17]);
    @(posedge clk); taskSwitchValid <= 1; loadData <= 32'h2_4002; tick;
    @(posedge clk); privilegedOp <= 1; tick;
    chk("legacy fault", 1, legacyFault);
    chk("legacy loads", 1, legacySegLoads);
    chk("nested", 1, nestedTask);
    for (int p = 0; p < 4; p += 3) begin
      apb(1, `FIU_OFF_FLAGS, {18'h0, p[1:0], 12'h2});
      @(posedge clk); ioCheck <= 1; tick;
      chk("io ok", p == 3, ioPermitted);
      chk("io bitmap", p != 3, ioNeedBitmap);
    end
    for (int m = 0; m < 2; m++) begin
      apb(1, `FIU_OFF_CONTROL, {13'h0, m[0], 18'h7});
      apb(1, `FIU_OFF_FLAGS, 32'h4_0002);
      @(posedge clk); memAccess <= 1; memMisaligned <= 1; tick;
      chk("align fault", m, alignFault);
    end
    for (int r = 0; r < 2; r++) begin
      apb(1, `FIU_OFF_FLAGS, {15'h0, r[0], 16'h2});
      @(posedge clk); dbgBreakHit <= 1; tick;
      chk("debug fault", !r, dbgFault);
    end
    apb(0, 8'h20, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rdat);
    $display("protection test done");
    wrap_up;
  end
endmodule // testbench
